/* design/siaio_top.sv */
// siaio_top: front lamps, discrete inputs and masked alarm lines with their register access
// assumes: link framing already decoded into one register request per cycle; all inputs synchronous to clk_sys
`include "siaio_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module siaio_top #(
  parameter int unsigned HOLDUP_CYCLES = `SIAIO_BIAS_HOLDUP_MS * `SIAIO_CLK_KHZ,
  parameter int unsigned SLOW_HALF     = `SIAIO_BLINK_SLOW_MS * `SIAIO_CLK_KHZ,
  parameter int unsigned FAST_HALF     = `SIAIO_BLINK_FAST_MS * `SIAIO_CLK_KHZ
) (
  input  wire logic                      clk_sys,
  input  wire logic                      reset,
  input  wire logic [7:0]                unit_address,
  input  wire logic                      req_valid,
  input  wire logic                      req_write,
  input  wire logic [7:0]                req_unit,
  input  wire logic [15:0]               req_addr,
  input  wire logic [15:0]               req_wdata,
  output logic                           rsp_valid,
  output logic                           rsp_exception,
  output logic [15:0]                    rsp_rdata,
  input  wire logic                      boot_active,
  input  wire logic                      boot_host_linked,
  input  wire logic                      boot_xfer_busy,
  input  wire logic                      boot_error,
  input  wire logic                      op_standby,
  input  wire logic                      op_processing,
  input  wire logic                      op_faulted,
  input  wire logic                      emergency_halt_input,
  input  wire logic                      contactor_request,
  input  wire logic                      bias_enable_input,
  input  wire logic                      island_control_input,
  input  wire logic [31:0]               fault_events,
  input  wire logic [31:0]               warning_events,
  input  wire logic [31:0]               state_events,
  input  wire logic [15:0]               misc_events,
  output logic                           lamp_power,
  output logic                           lamp_standby,
  output logic                           lamp_operating,
  output logic                           lamp_fault,
  output logic                           contactor_close,
  output logic                           emergency_halt_fault,
  output logic                           bias_supply_on,
  output var siaio_pkg::siaio_bias_st_t  bias_phase,
  output logic                           island_grid_forming,
  output logic                           alarm_line_one,
  output logic                           alarm_line_two
);
  import siaio_pkg::*;

  // ----------------------------------------
  // address decoding
  // ----------------------------------------
  function automatic logic [15:0] mask_base(input logic line, input siaio_kind_t kind);
    case ({line, kind})
      {1'b0, SIAIO_KIND_FAULT}: mask_base = `SIAIO_REG_A1_FAULT_MASK;
      {1'b0, SIAIO_KIND_WARN}:  mask_base = `SIAIO_REG_A1_WARN_MASK;
      {1'b0, SIAIO_KIND_STATE}: mask_base = `SIAIO_REG_A1_STATE_MASK;
      {1'b0, SIAIO_KIND_MISC}:  mask_base = `SIAIO_REG_A1_MISC_MASK;
      {1'b1, SIAIO_KIND_FAULT}: mask_base = `SIAIO_REG_A2_FAULT_MASK;
      {1'b1, SIAIO_KIND_WARN}:  mask_base = `SIAIO_REG_A2_WARN_MASK;
      {1'b1, SIAIO_KIND_STATE}: mask_base = `SIAIO_REG_A2_STATE_MASK;
      default:                  mask_base = `SIAIO_REG_A2_MISC_MASK;
    endcase
  endfunction

  // misc masks sit one register apart, so they hold a single low word
  function automatic logic mask_word(input logic [15:0] a, input logic line, input siaio_kind_t kind);
    mask_word = (a == mask_base(line, kind)) ||
                ((kind != SIAIO_KIND_MISC) && (a == mask_base(line, kind) + 16'h0001));
  endfunction

  logic [31:0]    mask_ff [2][4];
  logic [15:0]    pol_ff;
  logic [15:0]    isl_cfg_ff;
  logic [31:0]    fstat_ff;
  logic [31:0]    wstat_ff;
  logic           rsp_valid_ff;
  logic           rsp_exc_ff;
  logic [15:0]    rsp_rdata_ff;
  logic           addressed;
  logic           any_mask_hit;
  logic           status_hit;
  logic           cfg_hit;
  logic           wr_take;
  logic [15:0]    rd_word;
  logic [31:0]    cond [4];
  logic [1:0]     alarm_raw;
  logic           blink_slow;
  logic           blink_fast;

  // own unit for reads and writes, broadcast for writes only
  assign addressed  = req_valid && ((req_unit == unit_address) ||
                      (req_write && (req_unit == `SIAIO_BROADCAST_UNIT)));
  assign status_hit = (req_addr == `SIAIO_REG_FAULT_STATUS) || (req_addr == `SIAIO_REG_FAULT_STATUS + 16'h0001) ||
                      (req_addr == `SIAIO_REG_WARN_STATUS)  || (req_addr == `SIAIO_REG_WARN_STATUS + 16'h0001);
  assign cfg_hit    = (req_addr == `SIAIO_REG_ALARM_POLARITY) || (req_addr == `SIAIO_REG_ISLAND_CFG);

  always_comb begin
    any_mask_hit = 1'b0;
    for (int l = 0; l < 2; l++) begin
      for (int k = 0; k < 4; k++) begin
        if (mask_word(req_addr, 1'(l), siaio_kind_t'(k))) begin
          any_mask_hit = 1'b1;
        end
      end
    end
  end

  assign wr_take = addressed && req_write && (any_mask_hit || cfg_hit);

  // ----------------------------------------
  // mask, polarity and island registers
  // ----------------------------------------
  for (genvar gl = 0; gl < 2; gl++) begin : g_line
    for (genvar gk = 0; gk < 4; gk++) begin : g_kind
      localparam logic [15:0] BASE = mask_base(1'(gl), siaio_kind_t'(gk));
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          mask_ff[gl][gk] <= `SIAIO_MASK_RESET;
        end else if (wr_take && (gk == 3) && (req_addr == BASE)) begin
          mask_ff[gl][gk] <= {16'h0000, req_wdata};
        end else if (wr_take && (gk != 3) && (req_addr == BASE)) begin
          mask_ff[gl][gk][31:16] <= req_wdata;
        end else if (wr_take && (gk != 3) && (req_addr == BASE + 16'h0001)) begin
          mask_ff[gl][gk][15:0] <= req_wdata;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pol_ff <= `SIAIO_POL_RESET;
    end else if (wr_take && (req_addr == `SIAIO_REG_ALARM_POLARITY)) begin
      pol_ff <= req_wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      isl_cfg_ff <= `SIAIO_ISL_RESET;
    end else if (wr_take && (req_addr == `SIAIO_REG_ISLAND_CFG)) begin
      isl_cfg_ff <= req_wdata;
    end
  end

  // ----------------------------------------
  // status capture
  // ----------------------------------------
  // emergency halt fault folded into the fault word so masks can route it
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      fstat_ff <= 32'h0000_0000;
      wstat_ff <= 32'h0000_0000;
    end else begin
      fstat_ff <= fault_events | (32'(!emergency_halt_input) << `SIAIO_EMERGENCY_HALT_INPUT_FAULT_BIT);
      wstat_ff <= warning_events;
    end
  end

  // ----------------------------------------
  // read data and answer
  // ----------------------------------------
  always_comb begin
    rd_word = 16'h0000;
    if (req_addr == `SIAIO_REG_FAULT_STATUS)                rd_word = fstat_ff[31:16];
    if (req_addr == `SIAIO_REG_FAULT_STATUS + 16'h0001)     rd_word = fstat_ff[15:0];
    if (req_addr == `SIAIO_REG_WARN_STATUS)                 rd_word = wstat_ff[31:16];
    if (req_addr == `SIAIO_REG_WARN_STATUS + 16'h0001)      rd_word = wstat_ff[15:0];
    if (req_addr == `SIAIO_REG_ALARM_POLARITY)              rd_word = pol_ff;
    if (req_addr == `SIAIO_REG_ISLAND_CFG)                  rd_word = isl_cfg_ff;
    for (int l = 0; l < 2; l++) begin
      for (int k = 0; k < 4; k++) begin
        if ((k != 3) && (req_addr == mask_base(1'(l), siaio_kind_t'(k)))) rd_word = mask_ff[l][k][31:16];
        if ((k == 3) && (req_addr == mask_base(1'(l), siaio_kind_t'(k)))) rd_word = mask_ff[l][k][15:0];
        if ((k != 3) && (req_addr == mask_base(1'(l), siaio_kind_t'(k)) + 16'h0001)) rd_word = mask_ff[l][k][15:0];
      end
    end
  end

  // broadcast writes take effect silently; no answer goes back
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rsp_valid_ff <= 1'b0;
      rsp_exc_ff   <= 1'b0;
      rsp_rdata_ff <= 16'h0000;
    end else begin
      rsp_valid_ff <= addressed && !(req_write && (req_unit == `SIAIO_BROADCAST_UNIT));
      rsp_exc_ff   <= req_write ? !(any_mask_hit || cfg_hit) : !(any_mask_hit || cfg_hit || status_hit);
      rsp_rdata_ff <= req_write ? req_wdata : rd_word;
    end
  end

  // ----------------------------------------
  // alarm lines
  // ----------------------------------------
  assign cond[0] = fstat_ff;
  assign cond[1] = wstat_ff;
  assign cond[2] = state_events;
  assign cond[3] = {16'h0000, misc_events};

  always_comb begin
    alarm_raw = 2'b00;
    for (int l = 0; l < 2; l++) begin
      for (int k = 0; k < 4; k++) begin
        alarm_raw[l] = alarm_raw[l] | (|(cond[k] & mask_ff[l][k]));
      end
    end
  end

  logic alarm_one_ff;
  logic alarm_two_ff;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      alarm_one_ff <= 1'b0;
      alarm_two_ff <= 1'b0;
    end else begin
      alarm_one_ff <= alarm_raw[0] ^ pol_ff[`SIAIO_POL_LINE_ONE_BIT];
      alarm_two_ff <= alarm_raw[1] ^ pol_ff[`SIAIO_POL_LINE_TWO_BIT];
    end
  end

  // ----------------------------------------
  // emergency halt and island input
  // ----------------------------------------
  // hard gate: no register can override the halt input
  logic contactor_ff;
  logic halt_fault_ff;
  logic grid_form_ff;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      contactor_ff  <= 1'b0;
      halt_fault_ff <= 1'b0;
    end else begin
      contactor_ff  <= contactor_request && emergency_halt_input;
      halt_fault_ff <= !emergency_halt_input;
    end
  end

  // unconnected pin reads low, which keeps grid-tie unless the enable and invert bits are both set
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      grid_form_ff <= 1'b0;
    end else begin
      grid_form_ff <= isl_cfg_ff[`SIAIO_ISL_ENABLE_BIT] &&
                      (island_control_input ^ isl_cfg_ff[`SIAIO_ISL_INVERT_BIT]);
    end
  end

  // ----------------------------------------
  // bias supply hold-up
  // ----------------------------------------
  siaio_bias_st_t bias_st_ff;
  siaio_bias_st_t nxt_bias_st;
  logic [31:0]    hold_cnt_ff;
  logic           bias_on_ff;

  always_comb begin
    case (bias_st_ff)
      SIAIO_BIAS_OFF:  nxt_bias_st = bias_enable_input ? SIAIO_BIAS_ON : SIAIO_BIAS_OFF;
      SIAIO_BIAS_ON:   nxt_bias_st = bias_enable_input ? SIAIO_BIAS_ON : SIAIO_BIAS_HOLD;
      SIAIO_BIAS_HOLD: nxt_bias_st = bias_enable_input ? SIAIO_BIAS_ON :
                                     ((hold_cnt_ff == HOLDUP_CYCLES - 32'd1) ? SIAIO_BIAS_OFF : SIAIO_BIAS_HOLD);
      default:         nxt_bias_st = SIAIO_BIAS_OFF;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      bias_st_ff  <= SIAIO_BIAS_OFF;
      hold_cnt_ff <= 32'h0000_0000;
      bias_on_ff  <= 1'b0;
    end else begin
      bias_st_ff  <= nxt_bias_st;
      bias_on_ff  <= nxt_bias_st != SIAIO_BIAS_OFF;
      hold_cnt_ff <= (bias_st_ff == SIAIO_BIAS_HOLD) ? hold_cnt_ff + 32'd1 : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // lamps
  // ----------------------------------------
  siaio_blink #(
    .SLOW_HALF (SLOW_HALF),
    .FAST_HALF (FAST_HALF)
  ) u_blink (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .blink_slow (blink_slow),
    .blink_fast (blink_fast)
  );

  logic [3:0] lamp_ff;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      lamp_ff <= 4'h0;
    end else if (boot_active) begin
      lamp_ff <= {boot_error, boot_xfer_busy && blink_fast, boot_host_linked, blink_slow};
    end else begin
      lamp_ff <= {op_faulted || !emergency_halt_input, op_processing, op_standby,
                  bias_st_ff != SIAIO_BIAS_OFF};
    end
  end

  assign lamp_power           = lamp_ff[0];
  assign lamp_standby         = lamp_ff[1];
  assign lamp_operating       = lamp_ff[2];
  assign lamp_fault           = lamp_ff[3];
  assign contactor_close      = contactor_ff;
  assign emergency_halt_fault = halt_fault_ff;
  assign bias_supply_on       = bias_on_ff;
  assign bias_phase           = bias_st_ff;
  assign island_grid_forming  = grid_form_ff;
  assign alarm_line_one       = alarm_one_ff;
  assign alarm_line_two       = alarm_two_ff;
  assign rsp_valid            = rsp_valid_ff;
  assign rsp_exception        = rsp_exc_ff;
  assign rsp_rdata            = rsp_rdata_ff;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_normal_lamps;
    !boot_active |=> (lamp_power == ($past(bias_st_ff) != SIAIO_BIAS_OFF)) && (lamp_operating == $past(op_processing));
  endproperty
  a_normal_lamps: assert property (p_normal_lamps) else $error("normal lamp mismatch");

  property p_boot_power_blink;
    boot_active |=> lamp_power == $past(blink_slow);
  endproperty
  a_boot_power_blink: assert property (p_boot_power_blink) else $error("boot power lamp not blinking");

  property p_boot_linked;
    boot_active && boot_host_linked |=> lamp_standby;
  endproperty
  a_boot_linked: assert property (p_boot_linked) else $error("boot standby lamp off");

  property p_boot_xfer;
    boot_active |=> lamp_operating == ($past(boot_xfer_busy) && $past(blink_fast));
  endproperty
  a_boot_xfer: assert property (p_boot_xfer) else $error("boot operating lamp wrong");

  property p_boot_err;
    boot_active && boot_error |=> lamp_fault;
  endproperty
  a_boot_err: assert property (p_boot_err) else $error("boot fault lamp off");

  property p_halt_gate;
    !emergency_halt_input |=> !contactor_close && emergency_halt_fault && fstat_ff[`SIAIO_EMERGENCY_HALT_INPUT_FAULT_BIT];
  endproperty
  a_halt_gate: assert property (p_halt_gate) else $error("contactor closed without halt input");

  property p_bias_off_timing;
    $fell(bias_supply_on) |-> $past(hold_cnt_ff) == HOLDUP_CYCLES - 32'd1 && !$past(bias_enable_input);
  endproperty
  a_bias_off_timing: assert property (p_bias_off_timing) else $error("bias dropped early");

  property p_island_off;
    !isl_cfg_ff[`SIAIO_ISL_ENABLE_BIT] |=> !island_grid_forming;
  endproperty
  a_island_off: assert property (p_island_off) else $error("island switch while disabled");

  property p_alarm_one;
    ##1 alarm_line_one == ($past(alarm_raw[0]) ^ $past(pol_ff[`SIAIO_POL_LINE_ONE_BIT]));
  endproperty
  a_alarm_one: assert property (p_alarm_one) else $error("alarm one mismatch");

  property p_mask_block;
    (mask_ff[1][0] == 32'h0000_0000) && (mask_ff[1][1] == 32'h0000_0000) && (mask_ff[1][2] == 32'h0000_0000) &&
    (mask_ff[1][3] == 32'h0000_0000) |=> alarm_line_two == $past(pol_ff[`SIAIO_POL_LINE_TWO_BIT]);
  endproperty
  a_mask_block: assert property (p_mask_block) else $error("alarm two driven with masks clear");

  property p_bcast_write;
    req_valid && req_write && (req_unit == `SIAIO_BROADCAST_UNIT) && (req_addr == `SIAIO_REG_A1_FAULT_MASK + 16'h0001)
      |=> (mask_ff[0][0][15:0] == $past(req_wdata)) && !rsp_valid;
  endproperty
  a_bcast_write: assert property (p_bcast_write) else $error("broadcast write lost");

  property p_bcast_read;
    req_valid && !req_write && (req_unit == `SIAIO_BROADCAST_UNIT) && (unit_address != `SIAIO_BROADCAST_UNIT)
      |=> !rsp_valid;
  endproperty
  a_bcast_read: assert property (p_bcast_read) else $error("broadcast read answered");

  c_boot_xfer:  cover property (boot_active && boot_xfer_busy ##1 lamp_operating);
  c_alarm_rise: cover property ($rose(alarm_line_one));
  c_bias_hold:  cover property ($fell(bias_supply_on));
  c_bcast:      cover property (req_valid && req_write && (req_unit == `SIAIO_BROADCAST_UNIT));

endmodule // siaio_top

`default_nettype wire

/* design/siaio_cfg.svh */
// siaio_cfg.svh: register numbers, field positions, reset values and timing for the lamp/alarm block
// assumes: included by bare name; register numbers are the 16-bit register addresses as seen on the link
`ifndef SIAIO_CFG_SVH
`define SIAIO_CFG_SVH

// ----------------------------------------
// register numbers
// ----------------------------------------
`define SIAIO_REG_FAULT_STATUS   16'h9CC1
`define SIAIO_REG_WARN_STATUS    16'h9CC3
`define SIAIO_REG_A1_FAULT_MASK  16'hA13F
`define SIAIO_REG_A1_WARN_MASK   16'hA141
`define SIAIO_REG_A2_FAULT_MASK  16'hA143
`define SIAIO_REG_A2_WARN_MASK   16'hA145
`define SIAIO_REG_ALARM_POLARITY 16'hA147
`define SIAIO_REG_A1_STATE_MASK  16'hA148
`define SIAIO_REG_A2_STATE_MASK  16'hA14A
`define SIAIO_REG_A1_MISC_MASK   16'hA14C
`define SIAIO_REG_A2_MISC_MASK   16'hA14D
`define SIAIO_REG_ISLAND_CFG     16'hA73D
`define SIAIO_BROADCAST_UNIT     8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define SIAIO_POL_LINE_ONE_BIT   0
`define SIAIO_POL_LINE_TWO_BIT   1
`define SIAIO_ISL_ENABLE_BIT     0
`define SIAIO_ISL_INVERT_BIT     1
`define SIAIO_EMERGENCY_HALT_INPUT_FAULT_BIT    0

// ----------------------------------------
// reset values
// ----------------------------------------
`define SIAIO_MASK_RESET         32'h0000_0000
`define SIAIO_POL_RESET          16'h0000
`define SIAIO_ISL_RESET          16'h0000

// ----------------------------------------
// timing
// ----------------------------------------
`define SIAIO_CLK_KHZ            100000
`define SIAIO_BIAS_HOLDUP_MS     2500
`define SIAIO_BLINK_SLOW_MS      500
`define SIAIO_BLINK_FAST_MS      100

`endif

/* design/siaio_pkg.sv */
// siaio_pkg: types shared by the lamp/alarm block
// assumes: compiled before any module of the block
package siaio_pkg;

  // ----------------------------------------
  // mask kinds, index into the mask table
  // ----------------------------------------
  typedef enum logic [1:0] {
    SIAIO_KIND_FAULT = 2'b00,
    SIAIO_KIND_WARN  = 2'b01,
    SIAIO_KIND_STATE = 2'b10,
    SIAIO_KIND_MISC  = 2'b11
  } siaio_kind_t;

  // ----------------------------------------
  // bias supply phases
  // ----------------------------------------
  typedef enum logic [1:0] {
    SIAIO_BIAS_OFF  = 2'b00,
    SIAIO_BIAS_ON   = 2'b01,
    SIAIO_BIAS_HOLD = 2'b10
  } siaio_bias_st_t;

endpackage

/* design/siaio_blink.sv */
// siaio_blink: slow and fast square waves for the lamps
// assumes: one clock, asynchronous active-high reset
`timescale 1ns/10ps
`default_nettype none

module siaio_blink #(
  parameter int unsigned SLOW_HALF = 32'd50_000_000,
  parameter int unsigned FAST_HALF = 32'd10_000_000
) (
  input  wire logic clk_sys,
  input  wire logic reset,
  output logic      blink_slow,
  output logic      blink_fast
);

  logic [31:0] slow_cnt_ff;
  logic [31:0] fast_cnt_ff;
  logic        slow_ff;
  logic        fast_ff;

  // ----------------------------------------
  // free-running half-period counters
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      slow_cnt_ff <= 32'h0000_0000;
      slow_ff     <= 1'b0;
    end else if (slow_cnt_ff == SLOW_HALF - 32'd1) begin
      slow_cnt_ff <= 32'h0000_0000;
      slow_ff     <= ~slow_ff;
    end else begin
      slow_cnt_ff <= slow_cnt_ff + 32'd1;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      fast_cnt_ff <= 32'h0000_0000;
      fast_ff     <= 1'b0;
    end else if (fast_cnt_ff == FAST_HALF - 32'd1) begin
      fast_cnt_ff <= 32'h0000_0000;
      fast_ff     <= ~fast_ff;
    end else begin
      fast_cnt_ff <= fast_cnt_ff + 32'd1;
    end
  end

  assign blink_slow = slow_ff;
  assign blink_fast = fast_ff;

endmodule // siaio_blink

`default_nettype wire

/* dv/siaio_host.sv */
// siaio_host: host model issuing one register request per call
// assumes: requests launched at the falling edge of clk_sys
`timescale 1ns/10ps
`default_nettype none

module siaio_host (
  input  wire logic        clk_sys,
  output logic             req_valid,
  output logic             req_write,
  output logic [7:0]       req_unit,
  output logic [15:0]      req_addr,
  output logic [15:0]      req_wdata,
  input  wire logic        rsp_valid,
  input  wire logic        rsp_exception,
  input  wire logic [15:0] rsp_rdata
);
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_unit  = 8'h00;
    req_addr  = 16'h0000;
    req_wdata = 16'h0000;
  end

  // no ready: taken at the next rising edge, answer registered on that same edge
  task automatic xfer(input logic w, input logic [7:0] u, input logic [15:0] a, d,
                      output logic v, e, output logic [15:0] q);
    @(negedge clk_sys);
    req_valid = 1'b1;
    req_write = w;
    req_unit  = u;
    req_addr  = a;
    req_wdata = d;
    @(negedge clk_sys);
    v = rsp_valid;
    e = rsp_exception;
    q = rsp_rdata;
    req_valid = 1'b0;
    // released fields must not look like a held request
    req_addr  = ~a;
    req_wdata = ~d;
  endtask
endmodule // siaio_host

`default_nettype wire

/* dv/siaio_top_test.sv */
// siaio_top_test: self-checking bench for the lamp/alarm block
// assumes: host model drives the register port, bench drives the discretes
`timescale 1ns/10ps
`default_nettype none

module siaio_top_test;
  import siaio_pkg::*;
  localparam int HOLD = 20;
  typedef struct {logic [15:0] a, d; logic x;} siaio_row_t;
  siaio_row_t rows [8] = '{'{16'hA13F, 16'h8000, 1'b0}, '{16'hA140, 16'h0001, 1'b0},
    '{16'hA147, 16'h0002, 1'b0}, '{16'hA73D, 16'h0001, 1'b0}, '{16'hA14A, 16'h0010, 1'b0},
    '{16'hA14D, 16'h0004, 1'b0}, '{16'h9CC1, 16'h1234, 1'b1}, '{16'h0100, 16'h0001, 1'b1}};
  logic clk_sys, reset, rv, rw, rsv, rse, eh, be, bta, bhl, ber, ost, isl, cr, v, e;
  logic lp, ls, lo, lf, cc, ehf, bso, igf, a1, a2;
  logic [7:0] ru;
  logic [15:0] ra, rd, rsq, q;
  logic [31:0] fe;
  siaio_bias_st_t bph;
  int mismatches, checks_done, cyc;

  siaio_top #(.HOLDUP_CYCLES(HOLD), .SLOW_HALF(8), .FAST_HALF(2)) siaio_top_inst (
    .clk_sys(clk_sys), .reset(reset), .unit_address(8'h05), .req_valid(rv), .req_write(rw),
    .req_unit(ru), .req_addr(ra), .req_wdata(rd), .rsp_valid(rsv), .rsp_exception(rse),
    .rsp_rdata(rsq), .boot_active(bta), .boot_host_linked(bhl), .boot_xfer_busy(bhl),
    .boot_error(ber), .op_standby(ost), .op_processing(ost), .op_faulted(ost),
    .emergency_halt_input(eh), .contactor_request(cr), .bias_enable_input(be),
    .island_control_input(isl), .fault_events(fe), .warning_events(fe), .state_events(fe),
    .misc_events(fe[15:0]), .lamp_power(lp), .lamp_standby(ls), .lamp_operating(lo),
    .lamp_fault(lf), .contactor_close(cc), .emergency_halt_fault(ehf), .bias_supply_on(bso),
    .bias_phase(bph), .island_grid_forming(igf), .alarm_line_one(a1), .alarm_line_two(a2));

  siaio_host siaio_host_inst (.clk_sys(clk_sys), .req_valid(rv), .req_write(rw), .req_unit(ru),
    .req_addr(ra), .req_wdata(rd), .rsp_valid(rsv), .rsp_exception(rse), .rsp_rdata(rsq));

  task automatic chk(input logic [15:0] g, x);
    checks_done++;
    if (g !== x) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, g, x);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ceiling well above the roughly 80 cycles the tests need
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 2000) begin
      mismatches++;
      test_done();
    end
  end

  initial begin
    {reset, eh, be, bta, bhl, ber, ost, isl, cr, fe} = {9'h1C3, 32'h0};
    repeat (5) @(negedge clk_sys);
    chk(bph, SIAIO_BIAS_OFF);
    chk(a1, 1'b0);
    reset = 1'b0;
    $display("test reset done");
    foreach (rows[i]) begin
      siaio_host_inst.xfer(1'b1, 8'h05, rows[i].a, rows[i].d, v, e, q);
      chk(v, 1'b1);
      chk(e, rows[i].x);
      if (!rows[i].x) begin
        siaio_host_inst.xfer(1'b0, 8'h05, rows[i].a, 16'h0000, v, e, q);
        chk(q, rows[i].d);
      end
    end
    chk(a2, 1'b1);
    chk(igf, 1'b1);
    $display("test rows done");
    fe = 32'h2;
    repeat (3) @(negedge clk_sys);
    chk(a1, 1'b0);
    fe = 32'h3;
    @(negedge clk_sys);
    chk(a1, 1'b0);
    @(negedge clk_sys);
    chk(a1, 1'b1);
    siaio_host_inst.xfer(1'b1, 8'h00, 16'hA140, 16'h0000, v, e, q);
    chk(v, 1'b0);
    repeat (2) @(negedge clk_sys);
    chk(a1, 1'b0);
    siaio_host_inst.xfer(1'b0, 8'h00, 16'hA140, 16'h0000, v, e, q);
    chk(v, 1'b0);
    fe = 32'h4;
    repeat (2) @(negedge clk_sys);
    chk(a2, 1'b0);
    $display("test alarm done");
    chk(cc, 1'b1);
    cr = 1'b0;
    @(negedge clk_sys);
    chk(cc, 1'b0);
    {eh, ost, cr} = 3'b011;
    @(negedge clk_sys);
    chk({cc, ehf, ls, lf}, 4'h7);
    be = 1'b0;
    repeat (HOLD) @(negedge clk_sys);
    chk({bso, bph}, {1'b1, SIAIO_BIAS_HOLD});
    @(negedge clk_sys);
    chk(bso, 1'b0);
    {bta, bhl, ber, ost} = 4'hE;
    @(negedge clk_sys);
    chk({ls, lf}, 2'b11);
    q = {14'h0000, lo, lp};
    repeat (2) @(negedge clk_sys);
    chk(lo, !q[1]);
    repeat (6) @(negedge clk_sys);
    chk(lp, !q[0]);
    $display("test discretes done");
    reset = 1'b1;
    @(negedge clk_sys);
    chk({lp, ls, lo, lf, cc, ehf, bso, a1, a2, igf}, 10'h000);
    reset = 1'b0;
    siaio_host_inst.xfer(1'b0, 8'h05, 16'hA147, 16'h0000, v, e, q);
    chk(q, 16'h0000);
    $display("test mid reset done");
    test_done();
  end
endmodule // siaio_top_test

`default_nettype wire
